// File: logic/wwdog_consts.svh
// Register offsets, field positions, reset values and keys of the windowed watchdog.
`ifndef WWDOG_CONSTS_SVH
`define WWDOG_CONSTS_SVH
`define WWDOG_OFF_MODE      8'h00
`define WWDOG_OFF_TIMEOUT   8'h04
`define WWDOG_OFF_FEED      8'h08
`define WWDOG_OFF_COUNT     8'h0c
`define WWDOG_OFF_WARN      8'h10
`define WWDOG_OFF_WINDOW    8'h14
`define WWDOG_OFF_STATUS    8'h18
`define WWDOG_OFF_MASK      8'h1c
`define WWDOG_MODE_EN_BIT   0
`define WWDOG_MODE_RST_BIT  1
`define WWDOG_MODE_WIN_BIT  2
`define WWDOG_ST_TIMEOUT    0
`define WWDOG_ST_WARN       1
`define WWDOG_ST_FAULT      2
`define WWDOG_ST_WDRESET    3
`define WWDOG_TIMEOUT_RST   24'hffffff
`define WWDOG_TIMEOUT_MIN   24'h000100
`define WWDOG_WARN_RST      24'h000000
`define WWDOG_WINDOW_RST    24'hffffff
`define WWDOG_KEY_FIRST     8'haa
`define WWDOG_KEY_SECOND    8'h55
`define WWDOG_PRESCALE_LAST 2'h3
`define WWDOG_RESP_OKAY     2'h0
`define WWDOG_RESP_SLVERR   2'h2
`endif

// File: logic/wwdog_pkg.sv
// Types shared by the windowed watchdog design.
package wwdog_pkg;
	typedef logic [23:0] wwdog_count_t;
	typedef struct packed {
		logic window_en;
		logic reset_en;
		logic enable;
	} wwdog_mode_t;
	typedef struct packed {
		logic wd_reset;
		logic fault;
		logic warn;
		logic timeout;
	} wwdog_status_t;
	typedef enum logic [2:0] {
		WWDOG_FEED_IDLE  = 3'b001,
		WWDOG_FEED_ARMED = 3'b010,
		WWDOG_FEED_DONE  = 3'b100
	} wwdog_feed_t;
endpackage

// File: logic/wwdog_top.sv
// Windowed watchdog timer with an AXI4-Lite register slave.
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wwdog_consts.svh"
module wwdog_top (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 wd_oscillator_clock,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output logic                      chip_reset,
	output logic                      irq,
	output wwdog_pkg::wwdog_status_t  status_flags
);
	import wwdog_pkg::*;

	logic [7:0]    aw_addr_q;
	logic          aw_full_q;
	logic [31:0]   w_data_q;
	logic [3:0]    w_strb_q;
	logic          w_full_q;
	logic          awready_q;
	logic          wready_q;
	logic          bvalid_q;
	logic [1:0]    bresp_q;
	logic          arready_q;
	logic          rvalid_q;
	logic [31:0]   rdata_q;
	logic [1:0]    rresp_q;
	logic          wr_go;
	logic          rd_go;
	logic          wr_hit;
	logic          rd_hit;
	wwdog_mode_t   mode_q;
	wwdog_count_t  timeout_q;
	wwdog_count_t  warn_q;
	wwdog_count_t  window_q;
	wwdog_count_t  count_q;
	wwdog_status_t status_q;
	wwdog_status_t mask_q;
	wwdog_status_t set_ev;
	wwdog_feed_t   feed_q;
	logic          osc_q;
	logic          osc_tick;
	logic [1:0]    pre_q;
	logic          dec;
	logic          reload;
	logic          bad_feed;
	logic          expired;
	logic          wd_event;
	logic          chip_reset_q;
	logic          irq_q;
	logic [31:0]   wr_val;
	logic [31:0]   rd_val;
	logic [31:0]   timeout_m;
	logic [31:0]   warn_m;
	logic [31:0]   window_m;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign chip_reset    = chip_reset_q;
	assign irq           = irq_q;
	assign status_flags  = status_q;

	// Address and data are held separately so the master may send either first.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			awready_q <= 1'b1;
		end else if (s_axi_awvalid && awready_q) begin
			aw_full_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
			awready_q <= 1'b0;
		end else if (bvalid_q && s_axi_bready) begin
			aw_full_q <= 1'b0;
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			wready_q <= 1'b1;
		end else if (s_axi_wvalid && wready_q) begin
			w_full_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
			wready_q <= 1'b0;
		end else if (bvalid_q && s_axi_bready) begin
			w_full_q <= 1'b0;
			wready_q <= 1'b1;
		end
	end

	assign wr_go = aw_full_q && w_full_q && !bvalid_q;
	assign wr_hit = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q <= `WWDOG_OFF_MASK);
	assign wr_val = w_data_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `WWDOG_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? `WWDOG_RESP_OKAY : `WWDOG_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign rd_go = s_axi_arvalid && arready_q;
	assign rd_hit = (s_axi_araddr[1:0] == 2'h0) &&
		(s_axi_araddr <= `WWDOG_OFF_MASK);

	always_comb begin
		rd_val = 32'h00000000;
		unique case (s_axi_araddr)
			`WWDOG_OFF_MODE:    rd_val = {29'h0000000, mode_q};
			`WWDOG_OFF_TIMEOUT: rd_val = {8'h00, timeout_q};
			`WWDOG_OFF_COUNT:   rd_val = {8'h00, count_q};
			`WWDOG_OFF_WARN:    rd_val = {8'h00, warn_q};
			`WWDOG_OFF_WINDOW:  rd_val = {8'h00, window_q};
			`WWDOG_OFF_STATUS:  rd_val = {28'h0000000, status_q};
			`WWDOG_OFF_MASK:    rd_val = {28'h0000000, mask_q};
			default:            rd_val = 32'h00000000;
		endcase
	end

	// One read at a time keeps the answer simple: arready drops until taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= `WWDOG_RESP_OKAY;
		end else if (rd_go) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_val;
			rresp_q   <= rd_hit ? `WWDOG_RESP_OKAY : `WWDOG_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	// The oscillator is sampled as a plain input, so each level needs one clock.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_q <= 1'b0;
		end else begin
			osc_q <= wd_oscillator_clock;
		end
	end

	assign osc_tick = wd_oscillator_clock && !osc_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_q <= 2'h0;
		end else if (!mode_q.enable || reload) begin
			pre_q <= 2'h0;
		end else if (osc_tick) begin
			pre_q <= pre_q + 2'h1;
		end
	end

	assign dec = mode_q.enable && osc_tick &&
		(pre_q == `WWDOG_PRESCALE_LAST);
	assign expired = dec && (count_q == 24'h000000);

	// Feed sequence tracker; any other register access between keys breaks it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			feed_q <= WWDOG_FEED_IDLE;
		end else begin
			unique case (feed_q)
				WWDOG_FEED_IDLE: begin
					if (wr_go && aw_addr_q == `WWDOG_OFF_FEED && w_strb_q[0] &&
						wr_val[7:0] == `WWDOG_KEY_FIRST) begin
						feed_q <= WWDOG_FEED_ARMED;
					end
				end
				WWDOG_FEED_ARMED: begin
					if (wr_go && aw_addr_q == `WWDOG_OFF_FEED && w_strb_q[0] &&
						wr_val[7:0] == `WWDOG_KEY_SECOND) begin
						feed_q <= WWDOG_FEED_DONE;
					end else if (wr_go || rd_go) begin
						feed_q <= WWDOG_FEED_IDLE;
					end
				end
				WWDOG_FEED_DONE: begin
					feed_q <= WWDOG_FEED_IDLE;
				end
				default: begin
					feed_q <= WWDOG_FEED_IDLE;
				end
			endcase
		end
	end

	// A broken pair or a reload above the window raises fault, or wd_reset and a chip reset when reset_en is set.
	assign bad_feed = mode_q.enable && feed_q == WWDOG_FEED_ARMED &&
		(rd_go || (wr_go && !(aw_addr_q == `WWDOG_OFF_FEED && w_strb_q[0] &&
		wr_val[7:0] == `WWDOG_KEY_SECOND)));
	assign reload = feed_q == WWDOG_FEED_DONE && !(mode_q.window_en &&
		count_q > window_q);
	assign wd_event = expired || bad_feed ||
		(mode_q.enable && feed_q == WWDOG_FEED_DONE && !reload);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= `WWDOG_TIMEOUT_RST;
		end else if (wd_event || reload || !mode_q.enable) begin
			count_q <= timeout_q;
		end else if (dec) begin
			count_q <= count_q - 24'h000001;
		end
	end

	// Enable can only be set by software; an event is the sole way out.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= '0;
		end else begin
			if (wr_go && aw_addr_q == `WWDOG_OFF_MODE && w_strb_q[0]) begin
				mode_q.reset_en  <= wr_val[`WWDOG_MODE_RST_BIT];
				mode_q.window_en <= wr_val[`WWDOG_MODE_WIN_BIT];
				if (wr_val[`WWDOG_MODE_EN_BIT]) begin
					mode_q.enable <= 1'b1;
				end
			end
			if (wd_event) begin
				mode_q.enable <= 1'b0;
			end
		end
	end

	assign timeout_m = merge({8'h00, timeout_q}, wr_val, w_strb_q);
	assign warn_m    = merge({8'h00, warn_q}, wr_val, w_strb_q);
	assign window_m  = merge({8'h00, window_q}, wr_val, w_strb_q);

	// Timeout values under the minimum are raised so the period never collapses.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timeout_q <= `WWDOG_TIMEOUT_RST;
			warn_q    <= `WWDOG_WARN_RST;
			window_q  <= `WWDOG_WINDOW_RST;
			mask_q    <= '0;
		end else if (wr_go) begin
			if (aw_addr_q == `WWDOG_OFF_TIMEOUT) begin
				if (timeout_m[23:0] < `WWDOG_TIMEOUT_MIN) begin
					timeout_q <= `WWDOG_TIMEOUT_MIN;
				end else begin
					timeout_q <= timeout_m[23:0];
				end
			end
			if (aw_addr_q == `WWDOG_OFF_WARN) begin
				warn_q <= warn_m[23:0];
			end
			if (aw_addr_q == `WWDOG_OFF_WINDOW) begin
				window_q <= window_m[23:0];
			end
			if (aw_addr_q == `WWDOG_OFF_MASK && w_strb_q[0]) begin
				mask_q <= wr_val[3:0];
			end
		end
	end

	always_comb begin
		set_ev = '0;
		set_ev.timeout  = expired && !mode_q.reset_en;
		set_ev.warn     = mode_q.enable && dec &&
			count_q == warn_q + 24'h000001;
		set_ev.fault    = (wd_event && !expired) && !mode_q.reset_en;
		set_ev.wd_reset = wd_event && mode_q.reset_en;
	end

	// Hardware set wins over a software clear landing in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= '0;
		end else if (wr_go && aw_addr_q == `WWDOG_OFF_STATUS && w_strb_q[0]) begin
			status_q <= (status_q & ~wr_val[3:0]) | set_ev;
		end else begin
			status_q <= status_q | set_ev;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chip_reset_q <= 1'b0;
		end else begin
			chip_reset_q <= wd_event && mode_q.reset_en;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & mask_q);
		end
	end

endmodule
`default_nettype wire

// File: testbench/wwdog_monitor.sv
// Checker of the windowed watchdog outputs.
`timescale 1ns/1ps
`default_nettype none
module wwdog_monitor (
	input wire logic                     aclk,
	input wire logic                     aresetn,
	input wire logic                     s_axi_arvalid,
	input wire logic                     s_axi_bvalid,
	input wire logic                     s_axi_rvalid,
	input wire logic                     chip_reset,
	input wire logic                     irq,
	input wire wwdog_pkg::wwdog_status_t status_flags
);
	import wwdog_pkg::*;
	// Bus windows are loose; status_flags is status_q itself, and only irq lags it by a cycle.
	wire logic acc = s_axi_bvalid || s_axi_rvalid;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_reset_pulse: assert property (
		chip_reset |=> !chip_reset [*8])
		else $error("chip reset too long or repeated");
	chk_reset_flag: assert property (
		chip_reset |-> ##[0:2] status_flags.wd_reset)
		else $error("reset flag not set");
	chk_flag_cause: assert property (
		$rose(status_flags.wd_reset) |-> (chip_reset || $past(chip_reset)
		|| $past(chip_reset, 2)) or ##[1:2] chip_reset)
		else $error("reset flag without chip reset");
	chk_flag_sticky: assert property (
		$fell(status_flags.warn) || $fell(status_flags.wd_reset) |-> ##[0:1]
		(s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)))
		else $error("flag cleared without a write");
	chk_irq_cause: assert property (
		irq |-> status_flags != 0 || $past(status_flags) != 0)
		else $error("interrupt without status");
	chk_fault_cause: assert property (
		$rose(status_flags.fault) |-> ##[0:1]
		(acc || $past(acc) || $past(acc, 2)))
		else $error("fault without register access");
	chk_timeout_quiet: assert property (
		$rose(status_flags.timeout) |-> !chip_reset && !$past(chip_reset))
		else $error("timeout flag with chip reset");
	chk_read_cause: assert property (
		$rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
		else $error("read answer without request");
	cov_reset: cover property (chip_reset);
	cov_warn: cover property ($rose(status_flags.warn));
	cov_fault: cover property ($rose(status_flags.fault));
endmodule
bind wwdog_top wwdog_monitor u_mon (
	.aclk, .aresetn, .s_axi_arvalid, .s_axi_bvalid,
	.s_axi_rvalid, .chip_reset, .irq, .status_flags
);
`default_nettype wire

// File: testbench/wwdog_top_test.sv
// Self-checking bench of the windowed watchdog.
`timescale 1ns/1ps
`default_nettype none
module wwdog_top_test;
	import wwdog_pkg::*;
	logic aclk = 0, aresetn = 0, wd_oscillator_clock = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, m [8];
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, chip_reset, irq;
	wwdog_status_t status_flags;
	int error_cnt = 0, check_count = 0, pulses = 0;
	wwdog_top uut (.aclk, .aresetn, .wd_oscillator_clock,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .chip_reset, .irq, .status_flags);
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) if (aresetn && chip_reset === 1'b1) pulses++;
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bit ta, tw;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		ta = 0;
		tw = 0;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) ta = 1;
			if (s_axi_wvalid && s_axi_wready) tw = 1;
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 0;
		rsp = s_axi_bresp;
		if (a == 8'h00) m[0] = m[0] & 1 | d & 7;
		if (a == 8'h04) m[1] = d[23:0] < 24'h100 ? 32'h100 : {8'h0, d[23:0]};
		if (a == 8'h10 || a == 8'h14) m[a[4:2]] = {8'h0, d[23:0]};
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 0;
		rsp = s_axi_rresp;
		check(s_axi_rdata, exp);
	endtask
	// Random tick spacing keeps the sampler honest about edge detection.
	task tick(input int n);
		repeat (n) begin
			repeat (2 + $urandom % 3) @(posedge aclk);
			wd_oscillator_clock <= 1;
			repeat (2 + $urandom % 3) @(posedge aclk);
			wd_oscillator_clock <= 0;
		end
		repeat (4) @(posedge aclk);
	endtask
	task rst;
		@(posedge aclk);
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		m = '{0, 32'hffffff, 0, 32'hffffff, 0, 32'hffffff, 0, 0};
	endtask
	task st(input logic [3:0] e);
		repeat (3) @(posedge aclk);
		check(32'(status_flags), e);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// The tests need about 10k cycles; the limit leaves a wide margin.
	initial begin
		#150us;
		error_cnt++;
		conclude;
	end
	initial begin
		void'($urandom(29382));
		rst;
		for (int i = 0; i < 9; i++) rd(8'(i * 4), i < 8 ? m[i] : 0);
		check(rsp, 2);
		wr(8'h22, $urandom);
		check(rsp, 2);
		wr(8'h04, 32'h10);
		check(rsp, 0);
		rd(8'h04, m[1]);
		wr(8'h14, $urandom);
		rd(8'h14, m[5]);
		$display("test map done");
		wr(8'h04, 0);
		wr(8'h10, 32'h80);
		wr(8'h00, 1);
		tick(20);
		rd(8'h0c, 32'hfb);
		tick(491);
		st(0);
		tick(1);
		st(4'h2);
		check(irq, 0);
		wr(8'h00, 0);
		rd(8'h00, 1);
		wr(8'h1c, 2);
		st(4'h2);
		check(irq, 1);
		wr(8'h18, 2);
		st(0);
		check(irq, 0);
		tick(515);
		st(0);
		tick(1);
		st(4'h1);
		rd(8'h00, 0);
		check(pulses, 0);
		$display("test expiry done");
		rst;
		wr(8'h04, 0);
		wr(8'h00, 1);
		tick(40);
		wr(8'h08, 32'haa);
		wr(8'h08, 32'h55);
		rd(8'h0c, 32'h100);
		wr(8'h08, 32'haa);
		rd(8'h0c, 32'h100);
		st(4'h4);
		rd(8'h00, 0);
		wr(8'h18, 32'hf);
		wr(8'h00, 3);
		wr(8'h08, 32'haa);
		wr(8'h08, 32'h12);
		st(4'h8);
		check(pulses, 1);
		$display("test feed done");
		rst;
		wr(8'h04, 0);
		wr(8'h14, 32'h80);
		wr(8'h00, 5);
		tick(8);
		wr(8'h08, 32'haa);
		wr(8'h08, 32'h55);
		st(4'h4);
		wr(8'h18, 4);
		wr(8'h00, 5);
		tick(516);
		wr(8'h08, 32'haa);
		wr(8'h08, 32'h55);
		rd(8'h0c, 32'h100);
		st(0);
		$display("test window done");
		conclude;
	end
endmodule
`default_nettype wire
